// file: src/eeprom_pe_ctrl.sv
// Program and erase control of the 2 KB nonvolatile array, with its Wishbone register slave.
// Assumes the array macro outside performs the cycle it is given and serves reads directly.
//
// Summary of operation
// - Stop-in-wait set freezes the module during wait mode; bit always read/write.
// - Protect-lock freezes protect bits; write once in normal, free in special modes.
// - Block protect register writable only when program enable and lock are clear.
// - Shadow protect set refuses program or erase of the shadow word.
// - Six protect bits guard regions of 1024, 512, 256, 128, 64, 64 bytes.
// - Normal mode ignores test register writes and reads it as zero.
// - Bulk-erase protect, set at reset, blocks bulk and row erase; conditional write.
// - Automatic shutdown clears program enable when the cycle finishes.
// - Erase size bits pick bulk, 32-byte row or single location; ignored when programming.
// - Single-location erase hits only the latched byte or aligned word.
// - Erase bit picks program or erase; erase, size, auto change only while idle.
// - Latch bit writable unless program enable is set or divider is zero.
// - Program enable sets only if latch already set; joint write sets latch only.
// - Program enable freezes control bits and applies the program voltage for the timed cycle.
// - Protected target: no cycle starts and program enable is never auto-cleared.
// - While program enable is set, array writes are ignored and latches hold.
// - Reset copies the shadow word into configuration and divider registers.
// - In normal mode divider registers take only the first write after reset.
// - No cycle starts while the ten-bit divider is zero.
// - Shadow enabled redirects the shadow word locations to the shadow word.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module eeprom_pe_ctrl #(
	parameter logic [15:0] CYCLE_TICKS = eeprom_pkg::CYCLE_TICKS_DEFAULT
) (
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire eeprom_pkg::wb_req_type WB_REQ_IN,
	output logic WB_ACK_OUT,
	output logic [31:0] WB_DAT_OUT,
	input wire logic WAIT_MODE_IN,
	input wire logic SPECIAL_MODE_N_IN,
	input wire logic [15:0] SHADOW_WORD_IN,
	output logic [10:0] ARRAY_ADDR_OUT,
	output logic ARRAY_SHADOW_SEL_OUT,
	input wire logic [15:0] ARRAY_RDATA_IN,
	output eeprom_pkg::nv_cmd_type NV_CMD_OUT,
	output logic DEBUG_LOCKOUT_DISABLE_OUT,
	output logic STOPPED_OUT
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic loaded;
		logic [7:0] cfg;
		logic lock_done;
		logic [9:0] div;
		logic divh_done;
		logic divl_done;
		logic [7:0] prot;
		logic [7:0] test;
		logic [7:0] prog;
		logic [10:0] laddr;
		logic [15:0] ldata;
		logic lword;
		logic lvalid;
		eeprom_pkg::op_state_type op;
		logic [15:0] ticks;
		logic start;
	} ctrl_state_type;

	ctrl_state_type s_r;
	ctrl_state_type s_nxt;

	logic req;
	logic wr;
	logic reg_sel;
	logic arr_sel;
	logic [7:0] idx;
	logic [10:0] arr_a;
	logic [7:0] wd;
	logic special;
	logic pgm;
	logic running;
	logic tick;
	logic blocked;
	logic lat_shadow;
	eeprom_pkg::erase_size_type size_sel;

	function automatic logic is_shadow(input logic [10:0] a, input logic shadow_disable);
		return !shadow_disable && (a[10:1] == eeprom_pkg::SHADOW_OFFSET[10:1]);
	endfunction

	assign req = WB_REQ_IN.cyc && WB_REQ_IN.stb;
	assign wr = req && WB_REQ_IN.we && s_r.ack;
	assign reg_sel = WB_REQ_IN.adr[15:10] == 6'h00;
	assign arr_sel = WB_REQ_IN.adr[15:13] == eeprom_pkg::ARRAY_WINDOW;
	assign idx = WB_REQ_IN.adr[9:2];
	assign arr_a = WB_REQ_IN.adr[12:2];
	assign wd = WB_REQ_IN.dat[7:0];
	assign special = !SPECIAL_MODE_N_IN;
	assign pgm = s_r.prog[eeprom_pkg::PROG_PGM];
	assign running = !(s_r.cfg[eeprom_pkg::CFG_SWAI] && WAIT_MODE_IN);
	assign lat_shadow = is_shadow(s_r.laddr, s_r.cfg[eeprom_pkg::CFG_SHADOW_OFF]);

	always_comb begin
		if (!s_r.prog[eeprom_pkg::PROG_BYTE] && !s_r.prog[eeprom_pkg::PROG_ROW]) begin
			size_sel = eeprom_pkg::SIZE_BULK;
		end else if (!s_r.prog[eeprom_pkg::PROG_BYTE]) begin
			size_sel = eeprom_pkg::SIZE_ROW;
		end else begin
			size_sel = eeprom_pkg::SIZE_LOC;
		end
	end

	eeprom_prescaler #(
		.W(10)
	) u_prescaler (
		.clk_in(CLK_SYS_IN),
		.reset_in(RESET_IN),
		.run_in(running),
		.div_in(s_r.div),
		.tick_out(tick)
	);

	eeprom_protect_check u_protect (
		.addr_in(s_r.laddr),
		.shadow_sel_in(lat_shadow),
		.shadow_en_in(!s_r.cfg[eeprom_pkg::CFG_SHADOW_OFF]),
		.erase_in(s_r.prog[eeprom_pkg::PROG_ERASE]),
		.size_in(size_sel),
		.block_guard_in(s_r.prot[5:0]),
		.shadow_guard_in(s_r.prot[eeprom_pkg::PROT_SHADOW]),
		.bulk_guard_in(s_r.prog[eeprom_pkg::PROG_BULK_GUARD]),
		.blocked_out(blocked)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.ack = req && !s_r.ack;
		if (req && !s_r.ack) begin
			s_nxt.rdata = 32'h0000_0000;
			if (reg_sel) begin
				case (idx)
					eeprom_pkg::IDX_DIV_HIGH: s_nxt.rdata[7:0] = {6'h00, s_r.div[9:8]};
					eeprom_pkg::IDX_DIV_LOW: s_nxt.rdata[7:0] = s_r.div[7:0];
					eeprom_pkg::IDX_CONFIG: s_nxt.rdata[7:0] = s_r.cfg;
					eeprom_pkg::IDX_PROTECT: s_nxt.rdata[7:0] = s_r.prot;
					eeprom_pkg::IDX_TEST: s_nxt.rdata[7:0] = special ? s_r.test : 8'h00;
					eeprom_pkg::IDX_PROG: s_nxt.rdata[7:0] = s_r.prog;
					default: s_nxt.rdata = 32'h0000_0000;
				endcase
			end else if (arr_sel) begin
				s_nxt.rdata = {16'h0000, ARRAY_RDATA_IN};
			end
		end
		if (s_r.op == eeprom_pkg::OP_RUN && running && tick) begin
			if (s_r.ticks >= CYCLE_TICKS - 16'h0001) begin
				s_nxt.op = eeprom_pkg::OP_IDLE;
				if (s_r.prog[eeprom_pkg::PROG_AUTO]) begin
					s_nxt.prog[eeprom_pkg::PROG_PGM] = 1'b0;
				end
			end else begin
				s_nxt.ticks = s_r.ticks + 16'h0001;
			end
		end
		if (!s_r.loaded) begin
			s_nxt.loaded = 1'b1;
			s_nxt.cfg[7:4] = SHADOW_WORD_IN[15:12];
			s_nxt.div = {SHADOW_WORD_IN[9:8], SHADOW_WORD_IN[7:0]};
		end else if (wr && reg_sel && WB_REQ_IN.sel[0]) begin
			case (idx)
				eeprom_pkg::IDX_DIV_HIGH: begin
					if (!s_r.prog[eeprom_pkg::PROG_LAT] && (special || !s_r.divh_done)) begin
						s_nxt.div[9:8] = wd[1:0];
						s_nxt.divh_done = 1'b1;
					end
				end
				eeprom_pkg::IDX_DIV_LOW: begin
					if (!s_r.prog[eeprom_pkg::PROG_LAT] && (special || !s_r.divl_done)) begin
						s_nxt.div[7:0] = wd;
						s_nxt.divl_done = 1'b1;
					end
				end
				eeprom_pkg::IDX_CONFIG: begin
					s_nxt.cfg[eeprom_pkg::CFG_SWAI] = wd[eeprom_pkg::CFG_SWAI];
					s_nxt.cfg[eeprom_pkg::CFG_SPARE] = wd[eeprom_pkg::CFG_SPARE];
					if (special) begin
						s_nxt.cfg[7:4] = wd[7:4];
						s_nxt.cfg[eeprom_pkg::CFG_LOCK] = wd[eeprom_pkg::CFG_LOCK];
					end else if (!s_r.lock_done) begin
						s_nxt.cfg[eeprom_pkg::CFG_LOCK] = wd[eeprom_pkg::CFG_LOCK];
						s_nxt.lock_done = 1'b1;
					end
				end
				eeprom_pkg::IDX_PROTECT: begin
					if (!pgm && !s_r.cfg[eeprom_pkg::CFG_LOCK]) begin
						s_nxt.prot = wd & eeprom_pkg::PROTECT_MASK;
					end
				end
				eeprom_pkg::IDX_TEST: begin
					if (special) begin
						s_nxt.test = wd;
					end
				end
				eeprom_pkg::IDX_PROG: begin
					if (!pgm) begin
						if (!s_r.cfg[eeprom_pkg::CFG_LOCK]) begin
							s_nxt.prog[eeprom_pkg::PROG_BULK_GUARD] = wd[eeprom_pkg::PROG_BULK_GUARD];
						end
						s_nxt.prog[5:2] = wd[5:2];
						if (s_r.div != 10'h000) begin
							s_nxt.prog[eeprom_pkg::PROG_LAT] = wd[eeprom_pkg::PROG_LAT];
							if (!wd[eeprom_pkg::PROG_LAT]) begin
								s_nxt.lvalid = 1'b0;
							end
						end
						if (wd[eeprom_pkg::PROG_PGM] && s_r.prog[eeprom_pkg::PROG_LAT]) begin
							s_nxt.prog[eeprom_pkg::PROG_PGM] = 1'b1;
							s_nxt.prog[eeprom_pkg::PROG_LAT] = 1'b1;
							s_nxt.ticks = 16'h0000;
							if (blocked || s_r.div == 10'h000) begin
								s_nxt.op = eeprom_pkg::OP_STALL;
							end else begin
								s_nxt.op = eeprom_pkg::OP_RUN;
								s_nxt.start = 1'b1;
							end
						end
					end else if (!wd[eeprom_pkg::PROG_PGM]) begin
						s_nxt.prog[eeprom_pkg::PROG_PGM] = 1'b0;
						s_nxt.op = eeprom_pkg::OP_IDLE;
					end
				end
				default: begin
					s_nxt.ack = s_nxt.ack;
				end
			endcase
		end else if (wr && arr_sel && s_r.prog[eeprom_pkg::PROG_LAT] && !pgm) begin
			if (WB_REQ_IN.sel[1:0] == 2'h3 && !arr_a[0]) begin
				s_nxt.laddr = arr_a;
				s_nxt.ldata = WB_REQ_IN.dat[15:0];
				s_nxt.lword = 1'b1;
				s_nxt.lvalid = 1'b1;
			end else if (WB_REQ_IN.sel[1:0] == 2'h1) begin
				s_nxt.laddr = arr_a;
				s_nxt.ldata = {8'h00, WB_REQ_IN.dat[7:0]};
				s_nxt.lword = 1'b0;
				s_nxt.lvalid = 1'b1;
			end
		end
		if (running == 1'b0 && s_r.op == eeprom_pkg::OP_RUN) begin
			s_nxt.ticks = s_r.ticks;
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			s_r <= '0;
			s_r.cfg <= eeprom_pkg::CONFIG_RESET;
			s_r.prot <= eeprom_pkg::PROTECT_RESET;
			s_r.prog <= eeprom_pkg::PROG_RESET;
			s_r.test <= eeprom_pkg::TEST_RESET;
			s_r.op <= eeprom_pkg::OP_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign WB_ACK_OUT = s_r.ack;
	assign WB_DAT_OUT = s_r.rdata;
	assign ARRAY_ADDR_OUT = arr_a;
	assign ARRAY_SHADOW_SEL_OUT = is_shadow(arr_a, s_r.cfg[eeprom_pkg::CFG_SHADOW_OFF]);
	assign NV_CMD_OUT = '{
		start: s_r.start,
		hv: pgm && s_r.op == eeprom_pkg::OP_RUN && running,
		erase: s_r.prog[eeprom_pkg::PROG_ERASE],
		size: size_sel,
		word: s_r.lword,
		shadow: lat_shadow,
		addr: s_r.laddr,
		data: s_r.ldata
	};
	assign DEBUG_LOCKOUT_DISABLE_OUT = s_r.cfg[eeprom_pkg::CFG_DEBUG_UNLOCK];
	assign STOPPED_OUT = !running;
endmodule
`default_nettype wire

// file: src/eeprom_pkg.sv
// Shared constants, register indices and carrier types for the nonvolatile array control.
// Assumes a 32-bit classic Wishbone bus with byte addresses and a 40 MHz system clock.
package eeprom_pkg;
	// Register indices; the byte address of a register is four times its index.
	localparam logic [7:0] IDX_DIV_HIGH = 8'hEE;
	localparam logic [7:0] IDX_DIV_LOW = 8'hEF;
	localparam logic [7:0] IDX_CONFIG = 8'hF0;
	localparam logic [7:0] IDX_PROTECT = 8'hF1;
	localparam logic [7:0] IDX_TEST = 8'hF2;
	localparam logic [7:0] IDX_PROG = 8'hF3;
	// Array window on the bus: ARRAY_WINDOW in byte address bits 15:13, plus four times the array offset.
	localparam logic [2:0] ARRAY_WINDOW = 3'h1;
	localparam logic [10:0] SHADOW_OFFSET = 11'h7C0;
	// Field positions.
	localparam int CFG_DEBUG_UNLOCK = 7;
	localparam int CFG_SHADOW_OFF = 6;
	localparam int CFG_FIXED = 3;
	localparam int CFG_SWAI = 2;
	localparam int CFG_LOCK = 1;
	localparam int CFG_SPARE = 0;
	localparam int PROT_SHADOW = 7;
	localparam int PROG_BULK_GUARD = 7;
	localparam int PROG_AUTO = 5;
	localparam int PROG_BYTE = 4;
	localparam int PROG_ROW = 3;
	localparam int PROG_ERASE = 2;
	localparam int PROG_LAT = 1;
	localparam int PROG_PGM = 0;
	// Values after reset and write masks.
	localparam logic [7:0] CONFIG_RESET = 8'h0C;
	localparam logic [7:0] PROTECT_RESET = 8'hBF;
	localparam logic [7:0] PROTECT_MASK = 8'hBF;
	localparam logic [7:0] PROG_RESET = 8'h80;
	localparam logic [7:0] PROG_MASK = 8'hBF;
	localparam logic [7:0] TEST_RESET = 8'h00;
	// Length of one program or erase cycle in self-time ticks.
	localparam logic [15:0] CYCLE_TICKS_DEFAULT = 16'h0100;

	typedef enum logic [1:0] {SIZE_BULK, SIZE_ROW, SIZE_LOC} erase_size_type;
	typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_STALL} op_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [15:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_type;

	typedef struct packed {
		logic start;
		logic hv;
		logic erase;
		erase_size_type size;
		logic word;
		logic shadow;
		logic [10:0] addr;
		logic [15:0] data;
	} nv_cmd_type;
endpackage

// file: src/eeprom_prescaler.sv
// Self-time prescaler: one tick every divider cycles of the system clock.
// Assumes the divider is stable while a cycle runs; a zero divider gives no tick.
`timescale 1ns/10ps
`default_nettype none
module eeprom_prescaler #(
	parameter int W = 10
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic run_in,
	input wire logic [W-1:0] div_in,
	output logic tick_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} pre_state_type;

	pre_state_type s_r;
	pre_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (run_in && div_in != '0) begin
			if (s_r.cnt >= div_in - W'(1)) begin
				s_nxt.cnt = '0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_out = s_r.tick;
endmodule
`default_nettype wire

// file: src/eeprom_protect_check.sv
// Decides whether a program or erase target is protected.
// Purely combinational; the caller samples the answer when it sets the enable.
`timescale 1ns/10ps
`default_nettype none
module eeprom_protect_check (
	input wire logic [10:0] addr_in,
	input wire logic shadow_sel_in,
	input wire logic shadow_en_in,
	input wire logic erase_in,
	input wire eeprom_pkg::erase_size_type size_in,
	input wire logic [5:0] block_guard_in,
	input wire logic shadow_guard_in,
	input wire logic bulk_guard_in,
	output logic blocked_out
);
	function automatic logic [5:0] region_of(input logic [10:0] a);
		logic [5:0] r;
		r = 6'h00;
		if (a < 11'h400) begin
			r[5] = 1'b1;
		end else if (a < 11'h600) begin
			r[4] = 1'b1;
		end else if (a < 11'h700) begin
			r[3] = 1'b1;
		end else if (a < 11'h780) begin
			r[2] = 1'b1;
		end else if (a < 11'h7C0) begin
			r[1] = 1'b1;
		end else begin
			r[0] = 1'b1;
		end
		return r;
	endfunction

	logic loc_hit;

	always_comb begin
		loc_hit = shadow_sel_in ? shadow_guard_in : |(region_of(addr_in) & block_guard_in);
		blocked_out = loc_hit;
		if (erase_in) begin
			case (size_in)
				eeprom_pkg::SIZE_BULK: begin
					blocked_out = bulk_guard_in || (|block_guard_in) || (shadow_en_in && shadow_guard_in);
				end
				eeprom_pkg::SIZE_ROW: begin
					blocked_out = bulk_guard_in || loc_hit;
				end
				default: begin
					blocked_out = loc_hit;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: verif/eeprom_pe_ctrl_chk.sv
// Concurrent checks on the ports of the program and erase control block.
// Assumes one clock domain and bus requests separated by at least one idle cycle.
`timescale 1ns/10ps
`default_nettype none
module eeprom_pe_ctrl_chk #(
	parameter logic [15:0] CYCLE_TICKS = 16'h0100
) (
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire eeprom_pkg::wb_req_type WB_REQ_IN,
	input wire logic WB_ACK_OUT,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WAIT_MODE_IN,
	input wire logic SPECIAL_MODE_N_IN,
	input wire logic [15:0] SHADOW_WORD_IN,
	input wire logic [10:0] ARRAY_ADDR_OUT,
	input wire logic ARRAY_SHADOW_SEL_OUT,
	input wire logic [15:0] ARRAY_RDATA_IN,
	input wire eeprom_pkg::nv_cmd_type NV_CMD_OUT,
	input wire logic DEBUG_LOCKOUT_DISABLE_OUT,
	input wire logic STOPPED_OUT
);
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RESET_IN);
	sequence test_read;
		WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_REQ_IN.we && !WB_ACK_OUT && SPECIAL_MODE_N_IN
			&& WB_REQ_IN.adr == {6'h00, eeprom_pkg::IDX_TEST, 2'h0};
	endsequence
	sequence run_start;
		NV_CMD_OUT.start && !STOPPED_OUT;
	endsequence
	chk_ack_once: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held longer than one cycle");
	chk_ack_next: assert property (WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack missing one cycle after request");
	chk_test_zero: assert property (test_read |=> WB_ACK_OUT && WB_DAT_OUT == 32'h0)
		else $error("test register not zero in normal mode");
	chk_stop_hv: assert property (STOPPED_OUT |-> !NV_CMD_OUT.hv)
		else $error("voltage applied while stopped");
	chk_start_hv: assert property (run_start |-> NV_CMD_OUT.hv ##1 !NV_CMD_OUT.start)
		else $error("start without voltage or longer than a pulse");
	chk_latch_hold: assert property (NV_CMD_OUT.hv && $past(NV_CMD_OUT.hv) |->
		$stable(NV_CMD_OUT.addr) && $stable(NV_CMD_OUT.data) && $stable(NV_CMD_OUT.erase))
		else $error("latched target changed during a cycle");
	chk_shadow_load: assert property ($fell(RESET_IN) |=>
		DEBUG_LOCKOUT_DISABLE_OUT == $past(SHADOW_WORD_IN[15]))
		else $error("configuration not loaded from shadow word");
	chk_shadow_addr: assert property (ARRAY_SHADOW_SEL_OUT |-> ARRAY_ADDR_OUT[10:1] == 10'h3E0)
		else $error("shadow select outside shadow word");
	chk_array_addr: assert property (ARRAY_ADDR_OUT == WB_REQ_IN.adr[12:2])
		else $error("array offset does not follow bus address");
endmodule
bind eeprom_pe_ctrl eeprom_pe_ctrl_chk #(.CYCLE_TICKS(CYCLE_TICKS)) i_eeprom_pe_ctrl_chk (
	.CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .WB_REQ_IN(WB_REQ_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .WB_DAT_OUT(WB_DAT_OUT), .WAIT_MODE_IN(WAIT_MODE_IN),
	.SPECIAL_MODE_N_IN(SPECIAL_MODE_N_IN), .SHADOW_WORD_IN(SHADOW_WORD_IN),
	.ARRAY_ADDR_OUT(ARRAY_ADDR_OUT), .ARRAY_SHADOW_SEL_OUT(ARRAY_SHADOW_SEL_OUT),
	.ARRAY_RDATA_IN(ARRAY_RDATA_IN), .NV_CMD_OUT(NV_CMD_OUT),
	.DEBUG_LOCKOUT_DISABLE_OUT(DEBUG_LOCKOUT_DISABLE_OUT), .STOPPED_OUT(STOPPED_OUT));
`default_nettype wire

// file: verif/eeprom_pe_ctrl_tb_top.sv
// Self-checking testbench for the program and erase control with a register model.
// Assumes the checker is bound to the design and a shortened cycle of four ticks.
`timescale 1ns/10ps
`default_nettype none
module eeprom_pe_ctrl_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	eeprom_pkg::wb_req_type req = '0;
	logic ack;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic wait_m = 1'b0;
	logic smode_n = 1'b1;
	logic [15:0] arr_in = 16'h0000;
	eeprom_pkg::nv_cmd_type cmd;
	logic stopped;
	int fails = 0;
	int n_compared = 0;
	int unsigned seed = 78382;
	int m[int];
	bit dw[2];
	bit ld = 1'b0;
	int top[6] = '{'h7FF, 'h7BF, 'h77F, 'h6FF, 'h5FF, 'h3FF};

	eeprom_pe_ctrl #(.CYCLE_TICKS(16'h0004)) i_eeprom_pe_ctrl (
		.CLK_SYS_IN(clk), .RESET_IN(rst), .WB_REQ_IN(req), .WB_ACK_OUT(ack),
		.WB_DAT_OUT(rdat), .WAIT_MODE_IN(wait_m), .SPECIAL_MODE_N_IN(smode_n),
		.SHADOW_WORD_IN(16'h8000), .ARRAY_ADDR_OUT(), .ARRAY_SHADOW_SEL_OUT(),
		.ARRAY_RDATA_IN(arr_in), .NV_CMD_OUT(cmd), .DEBUG_LOCKOUT_DISABLE_OUT(),
		.STOPPED_OUT(stopped));

	initial begin
		forever #12.5 clk = ~clk;
	end

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb(logic we, logic [15:0] adr, logic [3:0] sel, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) chk("ack", 1, 0);
		rd = rdat;
		req <= '0;
	endtask

	// Register model: applies a write as the block must.
	task automatic mw(int i, int v);
		int p;
		p = m['hF3];
		case (i)
			'hEE, 'hEF: if (!p[1] && !(smode_n && dw[i - 'hEE])) begin
				m[i] = v & (i == 'hEE ? 3 : 'hFF);
				dw[i - 'hEE] = 1'b1;
			end
			'hF0: begin
				m[i] = (smode_n ? m[i] & 'hF0 : v & 'hF0) | 8 | (v & 5)
					| ((smode_n && ld) ? m[i] & 2 : v & 2);
				ld = ld | smode_n;
			end
			'hF1: if (!p[0] && !m['hF0][1]) m[i] = v & 'hBF;
			'hF2: m[i] = smode_n ? m[i] : v & 'hFF;
			'hF3: if (p[0]) m[i] = (p & 'hFE) | (v & 1);
			else m[i] = (m['hF0][1] ? p & 'h80 : v & 'h80) | (v & 'h3C)
				| ((m['hEE] | m['hEF]) ? v & 2 : p & 2) | ((v & p & 2) ? v & 1 : 0);
			default: ;
		endcase
	endtask

	task automatic rw(int i, int v);
		wb(1'b1, 16'(i * 4), 4'h1, 32'(v));
		mw(i, v);
	endtask

	task automatic rc(int i);
		wb(1'b0, 16'(i * 4), 4'h1, 32'h0);
		chk($sformatf("register %h", i), 32'((i == 'hF2 && smode_n) ? 0 : m[i]), rd);
	endtask

	// One program or erase sequence on one target, with software cleanup.
	task automatic op(int bits, int off, logic [3:0] sel, logic go);
		int n;
		rw('hF3, bits | 2);
		wb(1'b1, {3'h1, 11'(off), 2'h0}, sel, rnd());
		rw('hF3, bits | 3);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmd.start !== 1'b1 && n < 40);
		chk("start", go, cmd.start);
		if (go) begin
			chk("addr", off, cmd.addr);
			chk("shadow", (off >> 1) == 'h3E0, cmd.shadow);
			chk("erase", bits[2], cmd.erase);
			if (bits[2]) chk("word", sel == 4'h3, cmd.word);
			if (bits[2]) chk("size", bits[4] ? eeprom_pkg::SIZE_LOC : bits[3] ?
				eeprom_pkg::SIZE_ROW : eeprom_pkg::SIZE_BULK, 32'(cmd.size));
			rw('hF3, (bits ^ 4) | 3);
			wb(1'b1, {3'h1, 11'(off ^ 2), 2'h0}, 4'h3, rnd());
			@(posedge clk);
			chk("held addr", off, cmd.addr);
			rc('hF3);
		end
		n = 0;
		if (go && bits[5]) begin
			do begin
				wb(1'b0, 16'h03CC, 4'h1, 32'h0);
				n++;
			end while (rd[0] !== 1'b0 && n < 30);
			m['hF3] &= 'hFE;
		end else repeat (60) @(posedge clk);
		rc('hF3);
		if (m['hF3] & 1) rw('hF3, bits | 2);
		wb(1'b1, {3'h1, 11'(off ^ 2), 2'h0}, sel, rnd());
		@(posedge clk);
		chk("next addr", off ^ 2, cmd.addr);
		rw('hF3, bits);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial begin
		m = '{'hEE: 0, 'hEF: 0, 'hF0: 'h8C, 'hF1: 'hBF, 'hF2: 0, 'hF3: 'h80};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 'hEE; i <= 'hF3; i++) rc(i);
		rw('hF3, 'h82);
		rc('hF3);
		rw('hEF, 8);
		rw('hEF, 'h13);
		rw('hEE, 0);
		rw('hEE, 3);
		rc('hEF);
		rc('hEE);
		rw('hF2, 'hFF);
		rc('hF2);
		$display("reset, divider and test register done");
		rw('hF1, 0);
		rw('hF0, 'h8E);
		rw('hF1, 'h3F);
		rc('hF1);
		rw('hF3, 0);
		rc('hF3);
		rw('hF0, 'h8C);
		rc('hF0);
		smode_n <= 1'b0;
		rw('hF0, 'h8C);
		rc('hF0);
		rw('hF2, 'h5A);
		rc('hF2);
		smode_n <= 1'b1;
		rc('hF2);
		wait_m <= 1'b1;
		@(posedge clk);
		#1;
		chk("stopped", 1, stopped);
		rw('hF0, 'h88);
		rc('hF0);
		chk("stopped", 0, stopped);
		rw('hF0, 'h8C);
		wait_m <= 1'b0;
		rw('hF3, 3);
		rc('hF3);
		rw('hF3, 0);
		$display("lock, wait and latch done");
		for (int i = 0; i < 6; i++) begin
			rw('hF1, 1 << i);
			op('h20, top[i], 4'h1, 1'b0);
			rw('hF1, 'h3F ^ (1 << i));
			op('h20, top[i], 4'h1, 1'b1);
		end
		$display("block protection done");
		rw('hF1, 0);
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 3; s++) begin
				op((b << 7) | 'h24 | (s == 1 ? 8 : s == 2 ? 'h10 : 0), 'h040, 4'h3,
					!(b == 1 && s < 2));
			end
		end
		op('h00, 'h100, 4'h3, 1'b1);
		$display("erase modes and manual cycle done");
		rw('hF1, 'h80);
		op('h20, 'h7C0, 4'h3, 1'b0);
		rw('hF1, 0);
		op('h20, 'h7C0, 4'h3, 1'b1);
		arr_in <= 16'(rnd());
		wb(1'b0, {3'h1, 11'h010, 2'h0}, 4'h3, 32'h0);
		chk("array read", {16'h0, arr_in}, rd);
		$display("shadow word and array read done");
		print_verdict();
	end
endmodule
`default_nettype wire
